// file: src/tcm_top.sv
// tcm_top.sv: registers, counters, clearing, buffering and pin level of a six-channel timer
// assumes a single-master register port and pin inputs synchronous to CLOCK
`include "tcm_map.svh"

module tcm_top
  import tcm_pkg::*;
(
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic [6:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  input wire logic [3:0] EXT_CLOCK_PIN,
  output logic [5:0] PIN_LEVEL,
  output logic [5:0] PIN_DRIVE
);
  logic [7:0] ctrl_q [6];
  logic [5:0] mode_q [6];
  logic [7:0] ioh_q [6];
  logic [7:0] iol_q [6];
  logic [15:0] cnt_q [6];
  logic [15:0] gra_q [6];
  logic [15:0] grb_q [6];
  logic [15:0] grc_q [6];
  logic [15:0] grd_q [6];
  logic [5:0] start_q;
  logic [5:0] sync_q;
  logic [5:0] ovf_q;
  logic [3:0] ext_q;
  logic [15:0] rd_d;
  logic [5:0] div_rise;
  logic [5:0] div_fall;
  logic [5:0] step_up;
  logic [5:0] step_dn;
  logic [5:0] casc;
  logic [5:0] own_clr;
  logic [5:0] clr;
  logic [5:0] match_a;
  logic [5:0] match_b;
  logic [5:0] ovf_d;
  tcm_mode_t mode_eff [6];
  tcm_clr_t clr_kind [6];

  function automatic logic has_cd(input int c);
    has_cd = (c == 0) || (c == 3);
  endfunction

  function automatic tcm_mode_t mode_of(input int c, input logic [3:0] md);
    if (md[3] || md == 4'h1) mode_of = MODE_NORMAL;
    else if (md[2]) mode_of = has_cd(c) ? MODE_NORMAL : MODE_PHASE;
    else if (md[1]) mode_of = md[0] ? MODE_PWM2 : MODE_PWM1;
    else mode_of = MODE_NORMAL;
  endfunction

  function automatic tcm_clr_t clr_of(input int c, input logic [2:0] f);
    logic [2:0] v;
    v = has_cd(c) ? f : {1'b0, f[1:0]};
    case (v)
      3'h1: clr_of = CLR_A;
      3'h2: clr_of = CLR_B;
      3'h3, 3'h7: clr_of = CLR_SYNC;
      3'h5: clr_of = CLR_C;
      3'h6: clr_of = CLR_D;
      default: clr_of = CLR_NONE;
    endcase
  endfunction

  wire [2:0] a_ch = ADDR[6:4];
  wire [3:0] a_off = ADDR[3:0];
  wire [3:0] ext_rise = EXT_CLOCK_PIN & ~ext_q;
  wire [3:0] ext_fall = ~EXT_CLOCK_PIN & ext_q;
  wire com_wr = WR && (a_ch == `TCM_CH_COMMON);

  tcm_prescaler u_psc (
    .clk(CLOCK),
    .nrst(NRST),
    .div_rise(div_rise),
    .div_fall(div_fall)
  );

  for (genvar g = 0; g < 6; g++) begin : g_ch
    assign casc[g] = (g == 1) ? ovf_q[2] : (g == 4) ? ovf_q[5] : 1'b0;
    assign mode_eff[g] = mode_of(g, mode_q[g][3:0]);
    assign clr_kind[g] = clr_of(g, ctrl_q[g][`TCM_CLR_MSB:`TCM_CLR_LSB]);
    tcm_count_sel #(.CH(g)) u_sel (
      .ctrl(ctrl_q[g]),
      .mode(mode_eff[g]),
      .div_rise(div_rise),
      .div_fall(div_fall),
      .pin_lvl(EXT_CLOCK_PIN),
      .pin_rise(ext_rise),
      .pin_fall(ext_fall),
      .casc_in(casc[g]),
      .step_up(step_up[g]),
      .step_dn(step_dn[g])
    );
  end

  // a match is the up-count step taken while the counter equals the register
  always_comb begin
    for (int c = 0; c < 6; c++) begin
      match_a[c] = start_q[c] && step_up[c] && (cnt_q[c] == gra_q[c]);
      match_b[c] = start_q[c] && step_up[c] && (cnt_q[c] == grb_q[c]);
      case (clr_kind[c])
        CLR_A: own_clr[c] = match_a[c];
        CLR_B: own_clr[c] = match_b[c];
        // a buffer register never matches, so it cannot clear
        CLR_C: own_clr[c] = start_q[c] && step_up[c] && !mode_q[c][`TCM_BFA_BIT]
                            && (cnt_q[c] == grc_q[c]);
        CLR_D: own_clr[c] = start_q[c] && step_up[c] && !mode_q[c][`TCM_BFB_BIT]
                            && (cnt_q[c] == grd_q[c]);
        default: own_clr[c] = 1'b0;
      endcase
    end
  end

  // grouped clearing relies on software having set the sync bits
  wire sync_src = |(own_clr & sync_q);
  always_comb begin
    for (int c = 0; c < 6; c++) begin
      clr[c] = own_clr[c] || (start_q[c] && sync_q[c] && sync_src
               && clr_kind[c] == CLR_SYNC);
      ovf_d[c] = start_q[c] && !clr[c] && ((step_up[c] && cnt_q[c] == 16'hffff)
                 || (step_dn[c] && cnt_q[c] == 16'h0000));
    end
  end

  // mode and control should only change while stopped; nothing here enforces it
  always_ff @(posedge CLOCK) begin
    for (int c = 0; c < 6; c++) begin
      if (!NRST) begin
        ctrl_q[c] <= `TCM_CTRL_RST;
        mode_q[c] <= `TCM_MODE_RST;
        ioh_q[c] <= `TCM_IO_RST;
        iol_q[c] <= `TCM_IO_RST;
      end else if (WR && a_ch == 3'(c)) begin
        case (a_off)
          `TCM_OFF_CTRL: ctrl_q[c] <= {has_cd(c) & WDATA[7], WDATA[6:0]};
          `TCM_OFF_MODE: mode_q[c] <= {has_cd(c) ? WDATA[5:4] : 2'b00, WDATA[3:0]};
          `TCM_OFF_IOH: ioh_q[c] <= WDATA[7:0];
          `TCM_OFF_IOL: iol_q[c] <= has_cd(c) ? WDATA[7:0] : `TCM_IO_RST;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    for (int c = 0; c < 6; c++) begin
      if (!NRST) cnt_q[c] <= `TCM_CNT_RST;
      else if (WR && a_ch == 3'(c) && a_off == `TCM_OFF_CNT) cnt_q[c] <= WDATA;
      else if (clr[c]) cnt_q[c] <= `TCM_CNT_RST;
      else if (start_q[c] && step_up[c]) cnt_q[c] <= cnt_q[c] + 16'h0001;
      else if (start_q[c] && step_dn[c]) cnt_q[c] <= cnt_q[c] - 16'h0001;
    end
  end

  // buffer pairing: the buffer feeds its partner on the partner's match
  always_ff @(posedge CLOCK) begin
    for (int c = 0; c < 6; c++) begin
      if (!NRST) begin
        gra_q[c] <= `TCM_GR_RST;
        grb_q[c] <= `TCM_GR_RST;
        grc_q[c] <= `TCM_GR_RST;
        grd_q[c] <= `TCM_GR_RST;
      end else begin
        if (WR && a_ch == 3'(c) && a_off == `TCM_OFF_GRA) gra_q[c] <= WDATA;
        else if (match_a[c] && mode_q[c][`TCM_BFA_BIT]) gra_q[c] <= grc_q[c];
        if (WR && a_ch == 3'(c) && a_off == `TCM_OFF_GRB) grb_q[c] <= WDATA;
        else if (match_b[c] && mode_q[c][`TCM_BFB_BIT]) grb_q[c] <= grd_q[c];
        if (WR && a_ch == 3'(c) && a_off == `TCM_OFF_GRC && has_cd(c)) grc_q[c] <= WDATA;
        if (WR && a_ch == 3'(c) && a_off == `TCM_OFF_GRD && has_cd(c)) grd_q[c] <= WDATA;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      start_q <= '0;
      sync_q <= '0;
      ovf_q <= '0;
      ext_q <= '0;
    end else begin
      if (com_wr && a_off == `TCM_OFF_START) start_q <= WDATA[5:0];
      if (com_wr && a_off == `TCM_OFF_SYNC) sync_q <= WDATA[5:0];
      ovf_q <= ovf_d;
      ext_q <= EXT_CLOCK_PIN;
    end
  end

  // pin of register A: the io field of that register sets level and drive
  always_ff @(posedge CLOCK) begin
    for (int c = 0; c < 6; c++) begin
      if (!NRST) begin
        PIN_LEVEL[c] <= 1'b0;
        PIN_DRIVE[c] <= 1'b0;
      end else begin
        PIN_DRIVE[c] <= !ioh_q[c][3] && ioh_q[c][1:0] != 2'b00;
        if (!start_q[c]) PIN_LEVEL[c] <= ioh_q[c][2];
        else if (clr[c] && mode_eff[c] == MODE_PWM2) PIN_LEVEL[c] <= ioh_q[c][2];
        else if (match_a[c] && !ioh_q[c][3]) begin
          case (ioh_q[c][1:0])
            2'b01: PIN_LEVEL[c] <= 1'b0;
            2'b10: PIN_LEVEL[c] <= 1'b1;
            2'b11: PIN_LEVEL[c] <= !PIN_LEVEL[c];
            default: ;
          endcase
        end
      end
    end
  end

  // read mux; unmapped words and missing registers read as zero
  wire [2:0] rc = (a_ch < `TCM_CH_COMMON) ? a_ch : 3'h0;
  wire rcd = (rc == 3'h0) || (rc == 3'h3);
  always_comb begin
    rd_d = 16'h0000;
    if (a_ch == `TCM_CH_COMMON) begin
      if (a_off == `TCM_OFF_START) rd_d = {10'h000, start_q};
      else if (a_off == `TCM_OFF_SYNC) rd_d = {10'h000, sync_q};
    end else if (a_ch < `TCM_CH_COMMON) begin
      case (a_off)
        `TCM_OFF_CTRL: rd_d = {8'h00, ctrl_q[rc]};
        `TCM_OFF_MODE: rd_d = {8'h00, `TCM_MODE_FIXED, mode_q[rc]};
        `TCM_OFF_IOH: rd_d = {8'h00, ioh_q[rc]};
        `TCM_OFF_IOL: rd_d = rcd ? {8'h00, iol_q[rc]} : 16'h0000;
        `TCM_OFF_CNT: rd_d = cnt_q[rc];
        `TCM_OFF_GRA: rd_d = gra_q[rc];
        `TCM_OFF_GRB: rd_d = grb_q[rc];
        `TCM_OFF_GRC: rd_d = rcd ? grc_q[rc] : 16'h0000;
        `TCM_OFF_GRD: rd_d = rcd ? grd_q[rc] : 16'h0000;
        default: rd_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) RDATA <= 16'h0000;
    else RDATA <= RD ? rd_d : 16'h0000;
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  wire ch0_norm = mode_eff[0] == MODE_NORMAL;
  wire [2:0] psc0 = ctrl_q[0][2:0];
  wire [1:0] edg0 = ctrl_q[0][4:3];

  a_both_edges:
    assert property (start_q[0] && ch0_norm && psc0 == 3'h1 && edg0[1]
                     && (div_rise[0] || div_fall[0]) |-> step_up[0])
    else $error("both-edge count missed an edge");
  a_int_falling:
    assert property (start_q[0] && ch0_norm && psc0 == 3'h1 && edg0 == 2'b00
                     |-> step_up[0] == div_fall[0])
    else $error("internal clock not counted on falling edge");
  a_ext_rising:
    assert property (start_q[0] && ch0_norm && psc0 == 3'h4 && edg0 == 2'b00
                     && EXT_CLOCK_PIN[0] && !ext_q[0] |=> cnt_q[0] != $past(cnt_q[0]))
    else $error("external rising edge not counted");
  a_div1_every:
    assert property (start_q[0] && ch0_norm && psc0 == 3'h0 && !WR |-> step_up[0])
    else $error("undivided clock must count every cycle");
  a_cascade_src:
    assert property (start_q[1] && mode_eff[1] == MODE_NORMAL && ctrl_q[1][2:0] == 3'h7
                     |-> step_up[1] == ovf_q[2])
    else $error("channel 1 cascade not following channel 2 overflow");
  a_phase_ignore:
    assert property (mode_eff[1] == MODE_PHASE && ext_rise[1:0] == 2'b00
                     && ext_fall[1:0] == 2'b00 |-> !step_up[1] && !step_dn[1])
    else $error("phase mode counted without phase edge");
  a_buffer_noclr:
    assert property (clr_kind[0] == CLR_C && mode_q[0][`TCM_BFA_BIT] |-> !own_clr[0])
    else $error("buffer register cleared the counter");
  a_clear_zero:
    assert property (clr[0] && !WR |=> cnt_q[0] == 16'h0000)
    else $error("counter not cleared after clear event");
  a_ctrl_bit7:
    assert property (RD && a_ch == 3'h1 && a_off == `TCM_OFF_CTRL |=> !RDATA[7])
    else $error("reserved control bit read as one");
  a_mode_fixed:
    assert property (RD && a_ch == 3'h2 && a_off == `TCM_OFF_MODE
                     |=> RDATA[7:4] == 4'hc)
    else $error("reserved mode bits read wrong");
  a_stop_level:
    assert property (!start_q[0] ##1 !start_q[0] |-> PIN_LEVEL[0] == $past(ioh_q[0][2]))
    else $error("stopped pin not at initial level");

  c_pwm2_clear: cover property (mode_eff[0] == MODE_PWM2 && clr[0]);
  c_sync_clear: cover property (sync_src && clr[3] && !own_clr[3]);
  c_cascade: cover property (ctrl_q[4][2:0] == 3'h7 && step_up[4]);
  c_buffer_copy: cover property (match_a[0] && mode_q[0][`TCM_BFA_BIT]);
endmodule

// file: src/tcm_map.svh
// tcm_map.svh: register offsets, field positions, reset values and sizes of the timer
// assumes inclusion by bare name from the design files
`ifndef TCM_MAP_SVH
`define TCM_MAP_SVH
`define TCM_CH_N 6
`define TCM_CH_COMMON 3'h6
`define TCM_OFF_CTRL 4'h0
`define TCM_OFF_MODE 4'h1
`define TCM_OFF_IOH 4'h2
`define TCM_OFF_IOL 4'h3
`define TCM_OFF_CNT 4'h4
`define TCM_OFF_GRA 4'h5
`define TCM_OFF_GRB 4'h6
`define TCM_OFF_GRC 4'h7
`define TCM_OFF_GRD 4'h8
`define TCM_OFF_START 4'h0
`define TCM_OFF_SYNC 4'h1
`define TCM_CLR_MSB 7
`define TCM_CLR_LSB 5
`define TCM_EDGE_MSB 4
`define TCM_EDGE_LSB 3
`define TCM_PSC_MSB 2
`define TCM_PSC_LSB 0
`define TCM_BFB_BIT 5
`define TCM_BFA_BIT 4
`define TCM_MODE_FIXED 2'b11
`define TCM_CTRL_RST 8'h00
`define TCM_MODE_RST 6'h00
`define TCM_IO_RST 8'h00
`define TCM_CNT_RST 16'h0000
`define TCM_GR_RST 16'hffff
`define TCM_PSC_W 12
`endif

// file: src/tcm_pkg.sv
// tcm_pkg.sv: types shared by the timer modules
// assumes nothing beyond the map header
package tcm_pkg;
  typedef enum logic [3:0] {SRC_P1, SRC_P4, SRC_P16, SRC_P64, SRC_P256, SRC_P1024,
    SRC_P4096, SRC_PIN_A, SRC_PIN_B, SRC_PIN_C, SRC_PIN_D, SRC_CASCADE} tcm_src_t;
  typedef enum logic [2:0] {CLR_NONE, CLR_A, CLR_B, CLR_C, CLR_D, CLR_SYNC} tcm_clr_t;
  typedef enum logic [1:0] {MODE_NORMAL, MODE_PWM1, MODE_PWM2, MODE_PHASE} tcm_mode_t;
endpackage

// file: src/tcm_prescaler.sv
// tcm_prescaler.sv: free-running divider giving edge pulses of the divided clocks
// assumes one clock; the divided clocks exist only as one-cycle enables
`include "tcm_map.svh"
module tcm_prescaler
  import tcm_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  output logic [5:0] div_rise,
  output logic [5:0] div_fall
);
  logic [`TCM_PSC_W-1:0] cnt_q;
  logic [5:0] rise_d;
  logic [5:0] fall_d;

  function automatic logic [`TCM_PSC_W-1:0] low_mask(input int n);
    low_mask = `TCM_PSC_W'((1 << n) - 1);
  endfunction

  // rates 4,16,64,256,1024,4096: divided clock i is counter bit 2i+1
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      rise_d[i] = ((cnt_q & low_mask(2*i+1)) == low_mask(2*i+1)) && !cnt_q[2*i+1];
      fall_d[i] = (cnt_q & low_mask(2*i+2)) == low_mask(2*i+2);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_q <= '0;
      div_rise <= '0;
      div_fall <= '0;
    end else begin
      cnt_q <= cnt_q + `TCM_PSC_W'(1);
      div_rise <= rise_d;
      div_fall <= fall_d;
    end
  end
endmodule

// file: src/tcm_count_sel.sv
// tcm_count_sel.sv: count-source and edge selection of one channel
// assumes pin edges and divider pulses arrive as one-cycle enables
`include "tcm_map.svh"
module tcm_count_sel
  import tcm_pkg::*;
#(
  parameter int CH = 0
) (
  input wire logic [7:0] ctrl,
  input tcm_mode_t mode,
  input wire logic [5:0] div_rise,
  input wire logic [5:0] div_fall,
  input wire logic [3:0] pin_lvl,
  input wire logic [3:0] pin_rise,
  input wire logic [3:0] pin_fall,
  input wire logic casc_in,
  output logic step_up,
  output logic step_dn
);
  function automatic tcm_src_t src_of(input logic [2:0] p);
    case (p)
      3'h0: src_of = SRC_P1;
      3'h1: src_of = SRC_P4;
      3'h2: src_of = SRC_P16;
      3'h3: src_of = SRC_P64;
      3'h4: src_of = SRC_PIN_A;
      3'h5: src_of = (CH == 3) ? SRC_P1024 : (CH == 4 || CH == 5) ? SRC_PIN_C : SRC_PIN_B;
      3'h6: begin
        if (CH == 1 || CH == 3 || CH == 5) src_of = SRC_P256;
        else if (CH == 4) src_of = SRC_P1024;
        else src_of = SRC_PIN_C;
      end
      default: begin
        if (CH == 1 || CH == 4) src_of = SRC_CASCADE;
        else if (CH == 2) src_of = SRC_P1024;
        else if (CH == 3) src_of = SRC_P4096;
        else src_of = SRC_PIN_D;
      end
    endcase
  endfunction

  wire tcm_src_t src = src_of(ctrl[`TCM_PSC_MSB:`TCM_PSC_LSB]);
  wire [1:0] edge_sel = ctrl[`TCM_EDGE_MSB:`TCM_EDGE_LSB];
  wire [3:0] div_idx = 4'(src) - 4'(SRC_P4);
  wire [3:0] pin_idx = 4'(src) - 4'(SRC_PIN_A);
  wire d_r = div_rise[div_idx[2:0]];
  wire d_f = div_fall[div_idx[2:0]];
  wire p_r = pin_rise[pin_idx[1:0]];
  wire p_f = pin_fall[pin_idx[1:0]];
  // internal: 00 falling, 01 rising, 1x both; external is the mirror
  wire int_tick = edge_sel[1] ? (d_r | d_f) : (edge_sel[0] ? d_r : d_f);
  wire ext_tick = edge_sel[1] ? (p_r | p_f) : (edge_sel[0] ? p_f : p_r);
  // edge select has no meaning for the undivided clock or the cascade
  wire src_tick = (src == SRC_P1) ? 1'b1 :
                  (src == SRC_CASCADE) ? casc_in :
                  (src >= SRC_PIN_A) ? ext_tick : int_tick;
  // channels 1 and 5 decode pins a/b, channels 2 and 4 pins c/d
  localparam int PA = (CH == 2 || CH == 4) ? 2 : 0;
  wire a_lv = pin_lvl[PA];
  wire b_lv = pin_lvl[PA+1];
  wire a_e = pin_rise[PA] | pin_fall[PA];
  wire b_e = pin_rise[PA+1] | pin_fall[PA+1];
  // four-edge quadrature; the finer variants of the phase modes are not separated
  wire ph_up = (a_e && (a_lv != b_lv)) || (b_e && (a_lv == b_lv));
  wire ph_dn = (a_e && (a_lv == b_lv)) || (b_e && (a_lv != b_lv));
  wire phase = (mode == MODE_PHASE);

  assign step_up = phase ? ph_up : src_tick;
  assign step_dn = phase && ph_dn;
endmodule

// file: testbench/tcm_top_tb.sv
// tcm_top_tb.sv: self-checking bench for the six-channel timer
// assumes the src/ design files are compiled first; pins are driven synchronously
module tcm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [6:0] addr = 7'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] ext_pin = 4'h0;
  logic [15:0] rdata;
  logic [5:0] pin_level;
  logic [5:0] pin_drive;
  int miscompares = 0;
  int cmp_count = 0;
  logic [15:0] v;
  int ex;
  int c;
  int p;
  logic drv;
  logic [7:0] src_tab [15] = '{8'h10, 8'h15, 8'h1a, 8'h1f, 8'h30, 8'h35, 8'h50, 8'h55,
    8'h5a, 8'h70, 8'h90, 8'h96, 8'hb0, 8'hb6, 8'hbf};
  int ph_ch [4] = '{1, 2, 4, 5};
  int cl [6] = '{0, 1, 2, 4, 5, 6};
  int gr [8] = '{0, 2, 3, 0, 0, 4, 6, 0};
  logic [15:0] md [3] = '{16'h0001, 16'h0008, 16'h0004};
  logic [3:0] io [6] = '{4'h5, 4'h2, 4'h7, 4'h3, 4'h4, 4'hd};

  always #5 clock = ~clock;

  tcm_top i_dut (.CLOCK(clock), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .EXT_CLOCK_PIN(ext_pin), .PIN_LEVEL(pin_level), .PIN_DRIVE(pin_drive));

  function automatic logic [6:0] adr(input int ch, input logic [3:0] off);
    return {ch[2:0], off};
  endfunction

  task automatic stop_test;
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // lo == hi asks for an exact four-state match; otherwise a range for divider phase slack
  task automatic chk(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
    cmp_count++;
    if ((lo === hi) ? (got !== lo) : ((got >= lo && got <= hi) !== 1'b1)) begin
      miscompares++;
      $display("FAIL %0t: got %h, expected %h..%h", $time, got, lo, hi);
    end
  endtask

  // every access leaves one idle cycle so no strobe is assigned twice in one step
  task automatic wr_reg(input logic [6:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [15:0] lo, input logic [15:0] hi);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 v = rdata;
    @(posedge clock);
    chk(v, lo, hi);
  endtask

  task automatic steps(input int pn, input int n);
    repeat (n) begin
      ext_pin[pn] <= ~ext_pin[pn];
      repeat (3) @(posedge clock);
    end
  endtask

  task automatic run_pin(input int ch, input logic [7:0] ctl, input int pn, input int n,
      input logic [5:0] run);
    wr_reg(adr(ch, 4'h4), 16'h0000);
    wr_reg(adr(ch, 4'h0), {8'h00, ctl});
    wr_reg(7'h60, {10'h000, run});
    steps(pn, n);
    wr_reg(7'h60, 16'h0000);
    ext_pin <= 4'h0;
    @(posedge clock);
  endtask

  task automatic run_int(input int ch, input logic [7:0] ctl, input int cyc, input int e,
      input int tol);
    wr_reg(adr(ch, 4'h4), 16'h0000);
    wr_reg(adr(ch, 4'h0), {8'h00, ctl});
    wr_reg(7'h60, 16'h0001 << ch);
    repeat (cyc) @(posedge clock);
    wr_reg(7'h60, 16'h0000);
    rd_chk(adr(ch, 4'h4), 16'(e - tol), 16'(e + tol));
  endtask

  initial begin
    repeat (60000) @(posedge clock);
    miscompares++;
    stop_test();
  end

  initial begin
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    rd_chk(adr(0, 4'h0), 16'h0000, 16'h0000);
    rd_chk(adr(0, 4'h1), 16'h00c0, 16'h00c0);
    rd_chk(adr(3, 4'h8), 16'hffff, 16'hffff);
    chk({10'h000, pin_drive}, 16'h0000, 16'h0000);
    wr_reg(adr(1, 4'h0), 16'h00ff);
    rd_chk(adr(1, 4'h0), 16'h007f, 16'h007f);
    wr_reg(adr(1, 4'h1), 16'h003f);
    rd_chk(adr(1, 4'h1), 16'h00cf, 16'h00cf);
    wr_reg(adr(0, 4'h1), 16'h0037);
    rd_chk(adr(0, 4'h1), 16'h00f7, 16'h00f7);
    wr_reg(adr(1, 4'h3), 16'h00a5);
    rd_chk(adr(1, 4'h3), 16'h0000, 16'h0000);
    rd_chk(adr(0, 4'h9), 16'h0000, 16'h0000);
    wr_reg(adr(1, 4'h0), 16'h0000);
    wr_reg(adr(1, 4'h1), 16'h0000);
    wr_reg(adr(0, 4'h1), 16'h0000);
    // five toggles from low give three rising edges; a wrong pin gives none
    foreach (src_tab[i]) begin
      c = src_tab[i][7:5];
      run_pin(c, {5'h00, src_tab[i][4:2]}, src_tab[i][1:0], 5, 6'h01 << c);
      rd_chk(adr(c, 4'h4), 16'h0003, 16'h0003);
    end
    for (int k = 0; k < 4; k++) begin
      ex = k[1] ? 5 : (k[0] ? 2 : 3);
      run_pin(0, {3'h0, k[1:0], 3'h4}, 0, 5, 6'h01);
      rd_chk(adr(0, 4'h4), 16'(ex), 16'(ex));
    end
    run_int(0, 8'h00, 200, 202, 3);
    run_int(0, 8'h10, 200, 202, 3);
    run_int(0, 8'h01, 200, 50, 2);
    run_int(0, 8'h11, 200, 101, 3);
    run_int(0, 8'h02, 200, 13, 2);
    run_int(0, 8'h03, 200, 3, 1);
    run_int(1, 8'h06, 1200, 5, 1);
    run_int(2, 8'h07, 2100, 2, 1);
    run_int(4, 8'h06, 2100, 2, 1);
    run_int(5, 8'h06, 1200, 5, 1);
    for (int k = 0; k < 2; k++) begin
      c = k ? 4 : 1;
      wr_reg(adr(c + 1, 4'h4), 16'hfff0);
      wr_reg(adr(c + 1, 4'h0), 16'h0000);
      wr_reg(adr(c, 4'h4), 16'h0000);
      wr_reg(adr(c, 4'h0), 16'h0007);
      wr_reg(7'h60, 16'h0003 << c);
      repeat (40) @(posedge clock);
      wr_reg(7'h60, 16'h0000);
      rd_chk(adr(c, 4'h4), 16'h0001, 16'h0001);
    end
    // edge and source fields select a fast clock here, so any leak shows as counts
    for (int k = 0; k < 4; k++) begin
      c = ph_ch[k];
      p = (c == 1 || c == 5) ? 0 : 2;
      wr_reg(adr(c, 4'h1), 16'(4 + k));
      wr_reg(adr(c, 4'h4), 16'h0000);
      wr_reg(adr(c, 4'h0), 16'h0010);
      wr_reg(7'h60, 16'h0001 << c);
      repeat (30) @(posedge clock);
      rd_chk(adr(c, 4'h4), 16'h0000, 16'h0000);
      steps(p, 1);
      steps(p + 1, 1);
      steps(p, 1);
      steps(p + 1, 1);
      rd_chk(adr(c, 4'h4), 16'h0004, 16'h0004);
      wr_reg(7'h60, 16'h0000);
      wr_reg(adr(c, 4'h1), 16'h0000);
    end
    foreach (md[i]) begin
      wr_reg(adr(0, 4'h1), md[i]);
      run_pin(0, 8'h04, 0, 5, 6'h01);
      rd_chk(adr(0, 4'h4), 16'h0003, 16'h0003);
    end
    wr_reg(adr(0, 4'h1), 16'h0000);
    // clear code n compares against gr[n]: a=code 1, b=code 2, c=code 5, d=code 6
    wr_reg(adr(0, 4'h5), 16'(gr[1]));
    wr_reg(adr(0, 4'h6), 16'(gr[2]));
    wr_reg(adr(0, 4'h7), 16'(gr[5]));
    wr_reg(adr(0, 4'h8), 16'(gr[6]));
    foreach (cl[i]) begin
      ex = (gr[cl[i]] == 0) ? 7 : 7 % (gr[cl[i]] + 1);
      run_pin(0, 8'(cl[i] * 32 + 4), 0, 14, 6'h01);
      rd_chk(adr(0, 4'h4), 16'(ex), 16'(ex));
    end
    wr_reg(adr(0, 4'h1), 16'h0010);
    run_pin(0, 8'ha4, 0, 14, 6'h01);
    rd_chk(adr(0, 4'h4), 16'h0007, 16'h0007);
    rd_chk(adr(0, 4'h5), 16'h0004, 16'h0004);
    wr_reg(adr(0, 4'h1), 16'h0020);
    run_pin(0, 8'hc4, 0, 14, 6'h01);
    rd_chk(adr(0, 4'h4), 16'h0007, 16'h0007);
    rd_chk(adr(0, 4'h6), 16'h0006, 16'h0006);
    wr_reg(adr(0, 4'h1), 16'h0000);
    wr_reg(adr(0, 4'h5), 16'h0002);
    wr_reg(adr(3, 4'h5), 16'h0002);
    wr_reg(adr(3, 4'h0), 16'h0024);
    for (int k = 0; k < 3; k++) begin
      wr_reg(7'h61, (k == 2) ? 16'h0008 : 16'h0009);
      wr_reg(adr(3, 4'h4), 16'h0000);
      run_pin(0, (k == 1) ? 8'he4 : 8'h64, 0, 14, 6'h09);
      ex = (k == 2) ? 7 : 1;
      rd_chk(adr(0, 4'h4), 16'(ex), 16'(ex));
      rd_chk(adr(3, 4'h4), 16'h0001, 16'h0001);
    end
    wr_reg(7'h61, 16'h0000);
    foreach (io[i]) begin
      drv = !io[i][3] && io[i][1:0] != 2'h0;
      wr_reg(adr(0, 4'h2), {12'h000, io[i]});
      wr_reg(adr(0, 4'h4), 16'h0000);
      #1 chk({14'h0, pin_drive[0], pin_level[0] & drv}, {14'h0, drv, io[i][2] & drv},
        {14'h0, drv, io[i][2] & drv});
      @(posedge clock);
      if (drv) begin
        wr_reg(adr(0, 4'h0), 16'h0004);
        wr_reg(7'h60, 16'h0001);
        steps(0, 6);
        ex = (io[i][1:0] == 2'h1) ? 0 : ((io[i][1:0] == 2'h2) ? 1 : int'(!io[i][2]));
        #1 chk({15'h0, pin_level[0]}, 16'(ex), 16'(ex));
        @(posedge clock);
        wr_reg(7'h60, 16'h0000);
        #1 chk({15'h0, pin_level[0]}, {15'h0, io[i][2]}, {15'h0, io[i][2]});
        @(posedge clock);
      end
    end
    stop_test();
  end
endmodule
